/* File: testbench/swel_wake_model.sv */
`timescale 1ns/1ps

// Wake source model: peripherals, add-in cards and the alarm clock.
module swel_wake_model
  import swel_pkg::*;
(
  // Clock.
  input wire logic ref_clk,
  // Wake request lines, active high, idle low.
  output logic [SWEL_NSRC-1:0] pins
);
  // ----------------------------------------------------------------------
  // Wake pulses
  // ----------------------------------------------------------------------

  // Lines rest low until a source asks for a wake.
  initial pins = '0;

  // One source raises its line for three cycles, then lets it fall.
  // The line must fall before a second event can be seen.
  task automatic pulse(input int idx);
    @(posedge ref_clk);
    pins[idx] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    pins[idx] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps

// Self-checking bench for the sleep and wake block.
module testbench
  import swel_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic standby_present = 1'b1;
  logic main_power_on;
  logic led_green;
  logic led_amber;
  logic standby_led;
  logic irq;
  logic [SWEL_NSRC-1:0] pins;
  int n_fail = 0;
  int n_checks = 0;

  swel_wake_model model (.ref_clk(ref_clk), .pins(pins));

  swel_top dut (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pwr_btn(pins[SWEL_SRC_PWR_BTN]),
    .rtc_alarm(pins[SWEL_SRC_RTC]), .lan_wake(pins[SWEL_SRC_LAN]),
    .usb_activity(pins[SWEL_SRC_USB]), .pci_pme(pins[SWEL_SRC_PME]),
    .pcie_wake(pins[SWEL_SRC_PCIE]),
    .serial_activity(pins[SWEL_SRC_SERIAL]),
    .kbd_activity(pins[SWEL_SRC_KBD_ANY]),
    .kbd_hot_key(pins[SWEL_SRC_KBD_HOT]),
    .standby_present(standby_present), .main_power_on(main_power_on),
    .led_green(led_green), .led_amber(led_amber),
    .standby_led(standby_led), .irq(irq));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------

  // Compares a value seen with the value expected and counts both.
  task automatic check(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One classic bus cycle, held until ack is sampled high.
  task automatic wb_cycle(input logic [7:0] a, input logic w,
                          input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge ref_clk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Write and read wrappers.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, d, q);
  endtask

  task automatic rd_check(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
    logic [31:0] q;
    wb_cycle(a, 1'b0, 32'h0, q);
    check(nm, q, e);
  endtask

  // Requests a sleep state with the chosen control settings.
  task automatic sleep(input logic [1:0] req, input logic pme, rtc, dual);
    wr(SWEL_CTRL_OFS, {26'h0, dual, rtc, pme, 1'b1, req});
    repeat (3) @(posedge ref_clk);
  endtask

  // Returns to S0 by the power switch if needed, then clears status.
  task automatic to_s0;
    if (main_power_on !== 1'b1)
      model.pulse(SWEL_SRC_PWR_BTN);
    repeat (6) @(posedge ref_clk);
    wr(SWEL_IRQ_STAT_OFS, 32'h1ff);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------

  // Values after reset.
  task automatic t_reset;
    check("power_rst", 32'(main_power_on), 32'h1);
    check("green_rst", 32'(led_green), 32'h1);
    rd_check("state_rst", SWEL_STATE_OFS, 32'(SWEL_S0));
    rd_check("wake_en_rst", SWEL_WAKE_EN_OFS, 32'(SWEL_WAKE_EN_RST));
    rd_check("mask_rst", SWEL_IRQ_MASK_OFS, 32'(SWEL_IRQ_MASK_RST));
  endtask

  // Every source from every sleep state, all gates open.
  task automatic t_matrix;
    logic e;
    // Deep-state sources: power, RTC, LAN, PME, PCIe and hot key.
    logic [SWEL_NSRC-1:0] deep = 9'h137;
    for (int st = 0; st < 3; st++)
      for (int s = 0; s < SWEL_NSRC; s++)
      begin
        sleep(2'(st), 1'b1, 1'b1, s[0]);
        check("power_off", 32'(main_power_on), 32'h0);
        check("green_off", 32'(led_green), 32'h0);
        if (st == 0)
          check("amber", 32'(led_amber), 32'(s[0]));
        else
          check("amber_deep", 32'(led_amber), 32'h0);
        model.pulse(s);
        repeat (8) @(posedge ref_clk);
        e = (st == 0) || deep[s];
        check("woke", 32'(main_power_on), 32'(e));
        rd_check("state", SWEL_STATE_OFS,
                 e ? 32'(SWEL_S0) : 32'(SWEL_S3) << st);
        rd_check("cause", SWEL_IRQ_STAT_OFS,
                 e ? 32'h1 << s : 32'h0);
        to_s0;
      end
  endtask

  // Closed gates, S0 events and an unmapped address.
  task automatic t_gating;
    sleep(SWEL_REQ_S3, 1'b0, 1'b0, 1'b0);
    wr(SWEL_WAKE_EN_OFS, 32'h1ff & ~(32'h1 << SWEL_SRC_USB));
    model.pulse(SWEL_SRC_PME);
    model.pulse(SWEL_SRC_RTC);
    model.pulse(SWEL_SRC_USB);
    repeat (4) @(posedge ref_clk);
    check("gated", 32'(main_power_on), 32'h0);
    to_s0;
    wr(SWEL_WAKE_EN_OFS, 32'h1ff);
    model.pulse(SWEL_SRC_LAN);
    repeat (4) @(posedge ref_clk);
    rd_check("s0_stat", SWEL_IRQ_STAT_OFS, 32'h0);
    wr(8'hfc, 32'hffff_ffff);
    rd_check("unmapped", 8'hfc, 32'h0);
    rd_check("state_s0", SWEL_STATE_OFS, 32'(SWEL_S0));
  endtask

  // Sticky status, mask and write-one-to-clear.
  task automatic t_irq;
    wr(SWEL_IRQ_MASK_OFS, 32'h1 << SWEL_SRC_PWR_BTN);
    sleep(SWEL_REQ_S5, 1'b0, 1'b0, 1'b0);
    model.pulse(SWEL_SRC_LAN);
    repeat (8) @(posedge ref_clk);
    check("irq_masked", 32'(irq), 32'h0);
    rd_check("stat_lan", SWEL_IRQ_STAT_OFS, 32'h1 << SWEL_SRC_LAN);
    rd_check("source", SWEL_SOURCE_OFS, 32'h1 << SWEL_SRC_LAN);
    wr(SWEL_IRQ_STAT_OFS, 32'h1 << SWEL_SRC_LAN);
    rd_check("stat_clr", SWEL_IRQ_STAT_OFS, 32'h0);
    sleep(SWEL_REQ_S4, 1'b0, 1'b0, 1'b0);
    model.pulse(SWEL_SRC_PWR_BTN);
    repeat (8) @(posedge ref_clk);
    check("irq_on", 32'(irq), 32'h1);
    wr(SWEL_IRQ_STAT_OFS, 32'h1ff);
    repeat (2) @(posedge ref_clk);
    check("irq_off", 32'(irq), 32'h0);
    wr(SWEL_IRQ_MASK_OFS, 32'h0);
  endtask

  // Standby indicator follows standby power.
  task automatic t_standby;
    check("sb_on", 32'(standby_led), 32'h1);
    standby_present <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check("sb_off", 32'(standby_led), 32'h0);
    standby_present <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check("sb_back", 32'(standby_led), 32'h1);
  endtask

  // ----------------------------------------------------------------------
  // Clock, verdict, watchdog and main sequence
  // ----------------------------------------------------------------------

  // The 25 MHz clock.
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  // Prints the verdict and ends the run.
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    final_report;
  end

  // Reset, then every scenario in turn.
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_matrix;
    t_gating;
    t_irq;
    t_standby;
    final_report;
  end
endmodule

/* File: verilog/swel_pkg.sv */
package swel_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] SWEL_CTRL_OFS = 8'h00;
  localparam logic [7:0] SWEL_STATE_OFS = 8'h04;
  localparam logic [7:0] SWEL_WAKE_EN_OFS = 8'h08;
  localparam logic [7:0] SWEL_IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] SWEL_IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] SWEL_SOURCE_OFS = 8'h14;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int SWEL_CTRL_SLEEP_LSB = 0;
  localparam int SWEL_CTRL_GO_BIT = 2;
  localparam int SWEL_CTRL_PME_EN_BIT = 3;
  localparam int SWEL_CTRL_RTC_ARM_BIT = 4;
  localparam int SWEL_CTRL_DUAL_LED_BIT = 5;
  localparam int SWEL_CTRL_PS2_HOT_BIT = 6;

  // ----------------------------------------------------------------------
  // Wake source bit positions (status, mask, enable and latch share them)
  // ----------------------------------------------------------------------
  localparam int SWEL_NSRC = 9;
  localparam int SWEL_SRC_PWR_BTN = 0;
  localparam int SWEL_SRC_RTC = 1;
  localparam int SWEL_SRC_LAN = 2;
  localparam int SWEL_SRC_USB = 3;
  localparam int SWEL_SRC_PME = 4;
  localparam int SWEL_SRC_PCIE = 5;
  localparam int SWEL_SRC_SERIAL = 6;
  localparam int SWEL_SRC_KBD_ANY = 7;
  localparam int SWEL_SRC_KBD_HOT = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [8:0] SWEL_WAKE_EN_RST = 9'h1ff;
  localparam logic [8:0] SWEL_IRQ_MASK_RST = 9'h000;

  // ----------------------------------------------------------------------
  // Power states and the software sleep request encoding
  // ----------------------------------------------------------------------
  localparam logic [1:0] SWEL_REQ_S3 = 2'h0;
  localparam logic [1:0] SWEL_REQ_S4 = 2'h1;
  localparam logic [1:0] SWEL_REQ_S5 = 2'h2;

  typedef enum logic [3:0] {
    SWEL_S0 = 4'h1,
    SWEL_S3 = 4'h2,
    SWEL_S4 = 4'h4,
    SWEL_S5 = 4'h8
  } swel_state_e;

endpackage

/* File: verilog/swel_sync.sv */
`timescale 1ns/1ps

// Two-flop synchroniser bank for pin inputs.
module swel_sync
  import swel_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Asynchronous pins in, synchronous levels out.
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] levels
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } swel_sync_s;

  swel_sync_s r;
  swel_sync_s next_r;

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_r.meta = pins;
    next_r.sync = r.meta;
  end

  // Both stages clear under reset.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      r <= '0;
    else
      r <= next_r;
  end

  assign levels = r.sync;

  // Refuses a bank with no bits when the design is elaborated.
  if (WIDTH < 1)
  begin : g_width_check
    $error("swel_sync: WIDTH must be at least one.");
  end

endmodule

/* File: verilog/swel_top.sv */
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps

// Contract
// [R01] In S3 main supply stays off; LED amber if dual, dark if single.
// [R02] An enabled wake while sleeping returns to the last working state.
// [R03] USB activity wakes only from S3.
// [R04] PCI PME wakes from S3, S4, S5 only with wake-on-PME enabled.
// [R05] PCI Express wake line wakes from S3, S4 and S5.
// [R06] Any PS/2 keyboard activity wakes from S3.
// [R07] In S4 or S5 only the hot-key or power key wakes via PS/2.
// [R08] Serial port activity wakes only from S3.
// [R09] An armed RTC alarm wakes the system from S5.
// [R10] The standby indicator is lit whenever standby power is present.
// [R11] Power-managed add-in boards may signal the device to wake.
// [R12] Power switch, LAN and RTC alarm wake from S3, S4 and S5.
// [R13] Sources are ignored in S0; only enabled sources wake.
module swel_top
  import swel_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Wake source pins and standby power sense, active high after board inversion.
  input wire logic pwr_btn,
  input wire logic rtc_alarm,
  input wire logic lan_wake,
  input wire logic usb_activity,
  input wire logic pci_pme,
  input wire logic pcie_wake,
  input wire logic serial_activity,
  input wire logic kbd_activity,
  input wire logic kbd_hot_key,
  input wire logic standby_present,
  // Power and indicator outputs.
  output logic main_power_on,
  output logic led_green,
  output logic led_amber,
  output logic standby_led,
  output logic irq
);

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    swel_state_e state;
    logic [1:0] sleep_req;
    logic pme_en;
    logic rtc_arm;
    logic dual_led;
    logic [SWEL_NSRC-1:0] wake_en;
    logic [SWEL_NSRC-1:0] irq_stat;
    logic [SWEL_NSRC-1:0] irq_mask;
    logic [SWEL_NSRC-1:0] last_src;
    logic [SWEL_NSRC-1:0] prev_lvl;
    logic [31:0] dat;
    logic ack;
    logic main_power_on;
    logic led_green;
    logic led_amber;
    logic standby_led;
    logic irq;
  } swel_top_s;

  swel_top_s r;
  swel_top_s next_r;

  logic [SWEL_NSRC:0] raw_pins;
  logic [SWEL_NSRC:0] lvl_all;
  logic [SWEL_NSRC-1:0] lvl;
  logic [SWEL_NSRC-1:0] rise;
  logic [SWEL_NSRC-1:0] allowed;
  logic [SWEL_NSRC-1:0] hits;
  logic standby_lvl;
  logic wb_req;
  logic wb_wr;
  logic sleeping;

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  always_comb
  begin
    raw_pins = '0;
    raw_pins[SWEL_SRC_PWR_BTN] = pwr_btn;
    raw_pins[SWEL_SRC_RTC] = rtc_alarm;
    raw_pins[SWEL_SRC_LAN] = lan_wake;
    raw_pins[SWEL_SRC_USB] = usb_activity;
    raw_pins[SWEL_SRC_PME] = pci_pme;
    raw_pins[SWEL_SRC_PCIE] = pcie_wake;
    raw_pins[SWEL_SRC_SERIAL] = serial_activity;
    raw_pins[SWEL_SRC_KBD_ANY] = kbd_activity;
    raw_pins[SWEL_SRC_KBD_HOT] = kbd_hot_key;
    raw_pins[SWEL_NSRC] = standby_present;
  end

  swel_sync #(
    .WIDTH(SWEL_NSRC + 1)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pins(raw_pins),
    .levels(lvl_all)
  );

  assign lvl = lvl_all[SWEL_NSRC-1:0];
  assign standby_lvl = lvl_all[SWEL_NSRC];
  assign rise = lvl & ~r.prev_lvl;
  assign sleeping = (r.state != SWEL_S0);

  // ----------------------------------------------------------------------
  // Wake qualification per state
  // ----------------------------------------------------------------------
  always_comb
  begin
    allowed = '0;
    case (r.state)
      SWEL_S3:
      begin
        allowed = '1; // [R03] [R06] [R08] [R12]
        allowed[SWEL_SRC_PME] = r.pme_en; // [R04]
        allowed[SWEL_SRC_RTC] = r.rtc_arm;
      end
      SWEL_S4, SWEL_S5:
      begin
        allowed[SWEL_SRC_PWR_BTN] = 1'b1; // [R12]
        allowed[SWEL_SRC_LAN] = 1'b1; // [R12]
        allowed[SWEL_SRC_RTC] = r.rtc_arm; // [R09] [R12]
        allowed[SWEL_SRC_PME] = r.pme_en; // [R04] [R11]
        allowed[SWEL_SRC_PCIE] = 1'b1; // [R05] [R11]
        allowed[SWEL_SRC_KBD_HOT] = 1'b1; // [R07]
      end
      SWEL_S0: allowed = '0; // [R13]
      default: allowed = '0;
    endcase
  end

  assign hits = rise & allowed & r.wake_en; // [R13]

  assign wb_req = wb_cyc_i && wb_stb_i && !r.ack;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.prev_lvl = lvl;
    next_r.ack = wb_req;
    next_r.dat = '0;
    // Status bits are set by events; sets win over the write-one clear.
    if (wb_wr && wb_adr_i == SWEL_IRQ_STAT_OFS)
      next_r.irq_stat = r.irq_stat & ~wb_dat_i[SWEL_NSRC-1:0];
    if (wb_wr)
    begin
      case (wb_adr_i)
        SWEL_CTRL_OFS:
        begin
          next_r.sleep_req = wb_dat_i[SWEL_CTRL_SLEEP_LSB +: 2];
          next_r.pme_en = wb_dat_i[SWEL_CTRL_PME_EN_BIT];
          next_r.rtc_arm = wb_dat_i[SWEL_CTRL_RTC_ARM_BIT];
          next_r.dual_led = wb_dat_i[SWEL_CTRL_DUAL_LED_BIT];
          if (wb_dat_i[SWEL_CTRL_GO_BIT] && r.state == SWEL_S0)
          begin
            case (wb_dat_i[SWEL_CTRL_SLEEP_LSB +: 2])
              SWEL_REQ_S3: next_r.state = SWEL_S3;
              SWEL_REQ_S4: next_r.state = SWEL_S4;
              SWEL_REQ_S5: next_r.state = SWEL_S5;
              default: next_r.state = r.state;
            endcase
          end
        end
        SWEL_WAKE_EN_OFS: next_r.wake_en = wb_dat_i[SWEL_NSRC-1:0];
        SWEL_IRQ_MASK_OFS: next_r.irq_mask = wb_dat_i[SWEL_NSRC-1:0];
        default: next_r.wake_en = r.wake_en;
      endcase
    end
    // A qualified wake returns to the working state and records its cause.
    if (sleeping && hits != '0)
    begin
      next_r.state = SWEL_S0; // [R02]
      next_r.last_src = hits;
      next_r.irq_stat = next_r.irq_stat | hits;
    end
    // Read data; unmapped addresses read zero.
    if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        SWEL_CTRL_OFS:
          next_r.dat = {26'h0, r.dual_led, r.rtc_arm, r.pme_en, 1'b0,
                        r.sleep_req};
        SWEL_STATE_OFS: next_r.dat = {28'h0, r.state};
        SWEL_WAKE_EN_OFS: next_r.dat = {23'h0, r.wake_en};
        SWEL_IRQ_STAT_OFS: next_r.dat = {23'h0, r.irq_stat};
        SWEL_IRQ_MASK_OFS: next_r.dat = {23'h0, r.irq_mask};
        SWEL_SOURCE_OFS: next_r.dat = {23'h0, r.last_src};
        default: next_r.dat = '0;
      endcase
    end
    // Supply, green and amber outputs follow the state being entered.
    next_r.main_power_on = (next_r.state == SWEL_S0); // [R01]
    next_r.led_green = (next_r.state == SWEL_S0);
    next_r.led_amber = (next_r.state == SWEL_S3) && next_r.dual_led; // [R01]
    next_r.standby_led = standby_lvl; // [R10]
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      r <= '0;
      r.state <= SWEL_S0;
      r.wake_en <= SWEL_WAKE_EN_RST;
      r.irq_mask <= SWEL_IRQ_MASK_RST;
      r.main_power_on <= 1'b1;
      r.led_green <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign main_power_on = r.main_power_on;
  assign led_green = r.led_green;
  assign led_amber = r.led_amber;
  assign standby_led = r.standby_led;
  assign irq = r.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_s3_held;
    r.state == SWEL_S3 ##1 r.state == SWEL_S3;
  endsequence

  // The working state is back and the main supply is on in the same cycle.
  sequence s_back_to_s0;
    r.state == SWEL_S0 && main_power_on;
  endsequence

  property p_s3_power_off;
    @(posedge ref_clk) disable iff (reset)
      s_s3_held |-> !main_power_on && !led_green;
  endproperty
  a_s3_power_off: assert property (p_s3_power_off) // [R01]
    else $error("Main supply or green LED on during S3.");

  property p_s3_led;
    @(posedge ref_clk) disable iff (reset)
      s_s3_held |-> led_amber == r.dual_led;
  endproperty
  a_s3_led: assert property (p_s3_led) // [R01]
    else $error("Sleep LED colour wrong in S3.");

  property p_wake_restores;
    @(posedge ref_clk) disable iff (reset)
      (sleeping && hits != '0) |=> s_back_to_s0;
  endproperty
  a_wake_restores: assert property (p_wake_restores) // [R02]
    else $error("Enabled wake did not restore the working state.");

  property p_usb_deep;
    @(posedge ref_clk) disable iff (reset)
      (r.state != SWEL_S3) |-> !hits[SWEL_SRC_USB] && !hits[SWEL_SRC_SERIAL];
  endproperty
  a_usb_deep: assert property (p_usb_deep) // [R03] [R08]
    else $error("USB or serial wake outside S3.");

  property p_pme_gate;
    @(posedge ref_clk) disable iff (reset)
      hits[SWEL_SRC_PME] |-> r.pme_en;
  endproperty
  a_pme_gate: assert property (p_pme_gate) // [R04]
    else $error("PME wake taken while wake-on-PME is off.");

  property p_pcie_wake;
    @(posedge ref_clk) disable iff (reset)
      (sleeping && rise[SWEL_SRC_PCIE] && r.wake_en[SWEL_SRC_PCIE])
        |=> r.state == SWEL_S0;
  endproperty
  a_pcie_wake: assert property (p_pcie_wake) // [R05]
    else $error("PCI Express wake ignored while sleeping.");

  property p_kbd_deep;
    @(posedge ref_clk) disable iff (reset)
      (r.state == SWEL_S4 || r.state == SWEL_S5) |-> !hits[SWEL_SRC_KBD_ANY];
  endproperty
  a_kbd_deep: assert property (p_kbd_deep) // [R07]
    else $error("Plain keyboard activity woke from S4 or S5.");

  property p_s0_ignores;
    @(posedge ref_clk) disable iff (reset)
      (r.state == SWEL_S0 && !wb_wr) |=> $stable(r.last_src);
  endproperty
  a_s0_ignores: assert property (p_s0_ignores) // [R13]
    else $error("Wake source taken in the working state.");

  property p_standby;
    @(posedge ref_clk) disable iff (reset)
      standby_present [*4] |-> ##1 standby_led;
  endproperty
  a_standby: assert property (p_standby) // [R10]
    else $error("Standby indicator dark with standby power present.");

  property p_wake_sets_status;
    @(posedge ref_clk) disable iff (reset)
      (sleeping && hits != '0) |=> (r.irq_stat & $past(hits)) == $past(hits);
  endproperty
  a_wake_sets_status: assert property (p_wake_sets_status) // [R02]
    else $error("Wake cause lost from the status register.");

  property p_usb_s3;
    @(posedge ref_clk) disable iff (reset)
      (r.state == SWEL_S3 && rise[SWEL_SRC_USB]
        && r.wake_en[SWEL_SRC_USB]) |=> s_back_to_s0;
  endproperty
  a_usb_s3: assert property (p_usb_s3) // [R03]
    else $error("USB activity ignored in S3.");

  property p_kbd_s3;
    @(posedge ref_clk) disable iff (reset)
      (r.state == SWEL_S3 && rise[SWEL_SRC_KBD_ANY]
        && r.wake_en[SWEL_SRC_KBD_ANY]) |=> s_back_to_s0;
  endproperty
  a_kbd_s3: assert property (p_kbd_s3) // [R06]
    else $error("Keyboard activity ignored in S3.");

  property p_hot_deep;
    @(posedge ref_clk) disable iff (reset)
      ((r.state == SWEL_S4 || r.state == SWEL_S5) && rise[SWEL_SRC_KBD_HOT]
        && r.wake_en[SWEL_SRC_KBD_HOT]) |=> s_back_to_s0;
  endproperty
  a_hot_deep: assert property (p_hot_deep) // [R07]
    else $error("Keyboard hot key ignored in S4 or S5.");

  property p_rtc_s5;
    @(posedge ref_clk) disable iff (reset)
      (r.state == SWEL_S5 && r.rtc_arm && rise[SWEL_SRC_RTC]
        && r.wake_en[SWEL_SRC_RTC]) |=> s_back_to_s0;
  endproperty
  a_rtc_s5: assert property (p_rtc_s5) // [R09]
    else $error("Armed alarm did not wake from S5.");

endmodule
